// [design/rftx_regs.sv]
// Host register bank for timer, CRC result, bit framing and antenna driver control
`timescale 1ns/100ps
`default_nettype none
module rftx_regs (
   // Clock, reset, clock enable
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   // Parallel host port
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   // Core status inputs
   input wire logic [7:0] i_timer_count_value,
   input wire logic [7:0] i_crc_low_byte,
   input wire logic [7:0] i_crc_high_byte,
   input wire logic i_crc_done_flag,
   input wire logic i_crc_8bit,
   input wire logic i_rx_done,
   input wire logic i_tx_done,
   input wire logic i_encoder_data,
   input wire logic i_carrier,
   // Framing controls to receiver and transmitter
   output logic [2:0] o_receive_bit_offset,
   output logic [2:0] o_final_byte_bit_count,
   // Antenna drivers
   output logic o_modulator_input,
   output logic o_antenna_driver_a,
   output logic [5:0] o_cond_a,
   output logic o_antenna_driver_b,
   output logic [5:0] o_cond_b
);
   import rftx_pkg::*;

   typedef struct packed {
      logic [7:0] rdata;
      logic [2:0] rx_ofs;
      logic [2:0] last_bits;
      logic [1:0] src;
      logic force_full;
      logic b_inv;
      logic b_cw;
      logic b_en;
      logic a_en;
      logic [7:0] cw_cond;
      logic [7:0] mod_cond;
      logic mod_in;
   } rftx_state_t;

   rftx_state_t st;
   rftx_state_t next_st;
   logic [7:0] bf_reset;
   logic [7:0] dc_reset;
   logic [5:0] eff_mod_cond;

   assign bf_reset = RFTX_RST_BIT_FRAME;
   assign dc_reset = RFTX_RST_DRV_CTRL;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, auto clears and read mux
   always_comb begin
      next_st = st;
      // Completion clears; a host write in the same cycle is overridden
      if (i_rx_done) begin
         next_st.rx_ofs = 3'h0;
      end
      if (i_tx_done) begin
         next_st.last_bits = 3'h0;
      end
      if (i_wr) begin
         case (i_addr)
            RFTX_ADDR_BIT_FRAME: begin
               if (!i_rx_done) begin
                  next_st.rx_ofs = i_wdata[RFTX_RX_OFS_LSB +: 3];
               end
               if (!i_tx_done) begin
                  next_st.last_bits = i_wdata[RFTX_LAST_BITS_LSB +: 3];
               end
            end
            RFTX_ADDR_DRV_CTRL: begin
               // Bit 7 is not stored; host keeps it zero
               next_st.src = i_wdata[RFTX_SRC_LSB +: 2];
               next_st.force_full = i_wdata[RFTX_FORCE_BIT];
               next_st.b_inv = i_wdata[RFTX_B_INV_BIT];
               next_st.b_cw = i_wdata[RFTX_B_CW_BIT];
               next_st.b_en = i_wdata[RFTX_B_EN_BIT];
               next_st.a_en = i_wdata[RFTX_A_EN_BIT];
            end
            RFTX_ADDR_CW_COND: begin
               next_st.cw_cond = i_wdata;  // Upper bits kept as written
            end
            RFTX_ADDR_MOD_COND: begin
               next_st.mod_cond = i_wdata;
            end
            default: begin
            end
         endcase
      end
      // Read data registered: valid one cycle after the read strobe
      next_st.rdata = RFTX_READ_NONE;
      if (i_rd) begin
         case (i_addr)
            RFTX_ADDR_TIMER_COUNT: next_st.rdata = i_timer_count_value;
            RFTX_ADDR_CRC_LOW: begin
               if (i_crc_done_flag) begin
                  next_st.rdata = i_crc_low_byte;
               end
            end
            RFTX_ADDR_CRC_HIGH: begin
               if (i_crc_done_flag && !i_crc_8bit) begin
                  next_st.rdata = i_crc_high_byte;
               end
            end
            RFTX_ADDR_BIT_FRAME: begin
               next_st.rdata = {1'b0, st.rx_ofs, 1'b0, st.last_bits} & RFTX_MASK_BIT_FRAME;
            end
            RFTX_ADDR_DRV_CTRL: begin
               next_st.rdata = {1'b0, st.src, st.force_full, st.b_inv, st.b_cw, st.b_en,
                                st.a_en} & RFTX_MASK_DRV_CTRL;
            end
            RFTX_ADDR_CW_COND: next_st.rdata = st.cw_cond;
            RFTX_ADDR_MOD_COND: next_st.rdata = st.mod_cond;
            default: next_st.rdata = RFTX_READ_NONE;
         endcase
      end
      // Modulator input source; reserved code holds low as the safe choice
      case (st.src)
         RFTX_SRC_LOW: next_st.mod_in = 1'b0;
         RFTX_SRC_HIGH: next_st.mod_in = 1'b1;
         RFTX_SRC_ENC: next_st.mod_in = i_encoder_data;
         default: next_st.mod_in = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st <= '0;
         st.rx_ofs <= bf_reset[RFTX_RX_OFS_LSB +: 3];
         st.last_bits <= bf_reset[RFTX_LAST_BITS_LSB +: 3];
         st.src <= dc_reset[RFTX_SRC_LSB +: 2];
         st.force_full <= dc_reset[RFTX_FORCE_BIT];
         st.b_inv <= dc_reset[RFTX_B_INV_BIT];
         st.b_cw <= dc_reset[RFTX_B_CW_BIT];
         st.b_en <= dc_reset[RFTX_B_EN_BIT];
         st.a_en <= dc_reset[RFTX_A_EN_BIT];
         st.cw_cond <= RFTX_RST_CW_COND;
         st.mod_cond <= RFTX_RST_MOD_COND;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Driver lanes; forced full depth switches the keyed driver fully off
   assign eff_mod_cond = st.force_full ? RFTX_COND_OFF : st.mod_cond[5:0];

   // Driver A keys whenever the modulator input is high, enabled or not; it has no plain-carrier option
   rftx_driver_lane u_lane_a (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .i_rf_enable(st.a_en),
      .i_plain_carrier(1'b0),
      .i_invert(1'b0),
      .i_mod_active(st.mod_in),
      .i_carrier(i_carrier),
      .i_cw_cond(st.cw_cond[5:0]),
      .i_mod_cond(eff_mod_cond),
      .o_drive(o_antenna_driver_a),
      .o_cond(o_cond_a)
   );

   // Driver B adds inversion and plain-carrier choice
   rftx_driver_lane u_lane_b (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .i_rf_enable(st.b_en),
      .i_plain_carrier(st.b_cw),
      .i_invert(st.b_inv),
      .i_mod_active(st.mod_in),
      .i_carrier(i_carrier),
      .i_cw_cond(st.cw_cond[5:0]),
      .i_mod_cond(eff_mod_cond),
      .o_drive(o_antenna_driver_b),
      .o_cond(o_cond_b)
   );

   // Outputs straight from the state register
   assign o_rdata = st.rdata;
   assign o_receive_bit_offset = st.rx_ofs;
   assign o_final_byte_bit_count = st.last_bits;
   assign o_modulator_input = st.mod_in;

   ////////////////////////////////////////////////////////////////////////////
   // Checks, grouped by the field or output that they guard
   // Each one but cw_reset_a looks one edge after its cause, as the outputs are registered

   // Read path: live status bytes and CRC gating
   timer_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_rd && i_addr == RFTX_ADDR_TIMER_COUNT)
      |=> o_rdata == $past(i_timer_count_value))
      else $error("timer read mismatch");
   crc_low_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_rd && i_addr == RFTX_ADDR_CRC_LOW && i_crc_done_flag)
      |=> o_rdata == $past(i_crc_low_byte))
      else $error("crc low read mismatch");
   crc_high_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_rd && i_addr == RFTX_ADDR_CRC_HIGH && i_crc_done_flag && !i_crc_8bit)
      |=> o_rdata == $past(i_crc_high_byte))
      else $error("crc high read mismatch");
   crc_gate_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_rd && !i_crc_done_flag && (i_addr == RFTX_ADDR_CRC_LOW
       || i_addr == RFTX_ADDR_CRC_HIGH)) |=> o_rdata == RFTX_READ_NONE)
      else $error("crc read not gated");
   crc_high_8bit_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_rd && i_addr == RFTX_ADDR_CRC_HIGH && i_crc_8bit)
      |=> o_rdata == RFTX_READ_NONE)
      else $error("crc high byte shown for short crc");

   // Framing fields: host writes, completion clears and the frozen enable
   // A completion in the same cycle as a write must win, so writes exclude it
   rx_offset_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_wr && i_addr == RFTX_ADDR_BIT_FRAME && !i_rx_done)
      |=> o_receive_bit_offset == $past(i_wdata[RFTX_RX_OFS_LSB +: 3]))
      else $error("rx offset not written");
   tx_bits_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_wr && i_addr == RFTX_ADDR_BIT_FRAME && !i_tx_done)
      |=> o_final_byte_bit_count == $past(i_wdata[RFTX_LAST_BITS_LSB +: 3]))
      else $error("last bits not written");
   rx_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_rx_done) |=> o_receive_bit_offset == 3'h0)
      else $error("rx offset not cleared");
   tx_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_tx_done) |=> o_final_byte_bit_count == 3'h0)
      else $error("last bits not cleared");
   state_freeze_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !i_ce |=> $stable(o_rdata) && $stable(o_receive_bit_offset)
       && $stable(o_final_byte_bit_count) && $stable(o_modulator_input)
       && $stable(o_cond_a) && $stable(o_cond_b))
      else $error("state moved with clock enable low");

   // Control and conductance registers: writes, and the conductance reset values
   drv_ctrl_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_wr && i_addr == RFTX_ADDR_DRV_CTRL)
      |=> st.src == $past(i_wdata[RFTX_SRC_LSB +: 2])
       && st.force_full == $past(i_wdata[RFTX_FORCE_BIT]))
      else $error("driver control not written");
   cw_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_wr && i_addr == RFTX_ADDR_CW_COND) |=> st.cw_cond == $past(i_wdata))
      else $error("carrier conductance not written");
   mod_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_wr && i_addr == RFTX_ADDR_MOD_COND) |=> st.mod_cond == $past(i_wdata))
      else $error("keyed conductance not written");
   cw_reset_a: assert property (@(posedge i_clk)
      $rose(i_rstn)
      |-> st.cw_cond == RFTX_RST_CW_COND && st.mod_cond == RFTX_RST_MOD_COND)
      else $error("conductance reset wrong");

   // Modulator source: every code, the reserved one included
   mod_source_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.src == RFTX_SRC_HIGH) |=> o_modulator_input)
      else $error("modulator not high");
   mod_low_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.src == RFTX_SRC_LOW) |=> !o_modulator_input)
      else $error("modulator not low");
   mod_encoder_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.src == RFTX_SRC_ENC) |=> o_modulator_input == $past(i_encoder_data))
      else $error("modulator not following encoder");
   mod_reserved_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.src != RFTX_SRC_LOW && st.src != RFTX_SRC_HIGH && st.src != RFTX_SRC_ENC)
      |=> !o_modulator_input)
      else $error("reserved source not low");

   // Driver levels: enable, constant level and inversion
   a_enable_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.a_en) |=> o_antenna_driver_a == $past(i_carrier))
      else $error("driver a not carrier");
   a_disable_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && !st.a_en) |=> !o_antenna_driver_a)
      else $error("driver a not constant");
   b_disable_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && !st.b_en) |=> !o_antenna_driver_b)
      else $error("driver b not constant");
   b_enable_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.b_en && !st.b_inv) |=> o_antenna_driver_b == $past(i_carrier))
      else $error("driver b not carrier");
   b_invert_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.b_en && st.b_inv) |=> o_antenna_driver_b == !$past(i_carrier))
      else $error("driver b not inverted");

   // Conductance per lane: carrier level, keyed level and forced full depth
   // Full depth is checked apart, as it overrides the keyed register
   force_depth_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.force_full && st.mod_in && st.a_en) |=> o_cond_a == RFTX_COND_OFF)
      else $error("full depth not forced");
   b_force_depth_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.force_full && st.mod_in && !st.b_cw)
      |=> o_cond_b == RFTX_COND_OFF)
      else $error("full depth not forced on b");
   a_keyed_cond_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.mod_in && !st.force_full)
      |=> o_cond_a == $past(st.mod_cond[5:0]))
      else $error("driver a keyed conductance wrong");
   a_cw_cond_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && !st.mod_in) |=> o_cond_a == $past(st.cw_cond[5:0]))
      else $error("driver a carrier conductance wrong");
   b_plain_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.b_cw) |=> o_cond_b == $past(st.cw_cond[5:0]))
      else $error("driver b keyed in plain mode");
   b_cw_cond_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && !st.mod_in) |=> o_cond_b == $past(st.cw_cond[5:0]))
      else $error("driver b carrier conductance wrong");
   b_keyed_cond_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.mod_in && !st.b_cw && !st.force_full)
      |=> o_cond_b == $past(st.mod_cond[5:0]))
      else $error("driver b keyed conductance wrong");
endmodule // rftx_regs
`default_nettype wire

// [design/rftx_pkg.sv]
// Package of register offsets, field layouts and reset values for the reader framing registers
package rftx_pkg;
   // Register byte offsets on the parallel host port
   localparam logic [7:0] RFTX_ADDR_TIMER_COUNT = 8'h0c;
   localparam logic [7:0] RFTX_ADDR_CRC_LOW = 8'h0d;
   localparam logic [7:0] RFTX_ADDR_CRC_HIGH = 8'h0e;
   localparam logic [7:0] RFTX_ADDR_BIT_FRAME = 8'h0f;
   localparam logic [7:0] RFTX_ADDR_DRV_CTRL = 8'h11;
   localparam logic [7:0] RFTX_ADDR_CW_COND = 8'h12;
   localparam logic [7:0] RFTX_ADDR_MOD_COND = 8'h13;
   // Reset values
   localparam logic [7:0] RFTX_RST_BIT_FRAME = 8'h00;
   localparam logic [7:0] RFTX_RST_DRV_CTRL = 8'h48;
   localparam logic [7:0] RFTX_RST_CW_COND = 8'h3f;
   localparam logic [7:0] RFTX_RST_MOD_COND = 8'h05;
   // Field positions
   localparam int RFTX_RX_OFS_LSB = 4;
   localparam int RFTX_LAST_BITS_LSB = 0;
   localparam int RFTX_SRC_LSB = 5;
   localparam int RFTX_FORCE_BIT = 4;
   localparam int RFTX_B_INV_BIT = 3;
   localparam int RFTX_B_CW_BIT = 2;
   localparam int RFTX_B_EN_BIT = 1;
   localparam int RFTX_A_EN_BIT = 0;
   // Field masks of defined bits; the conductance registers also store bits 7:6
   localparam logic [7:0] RFTX_MASK_BIT_FRAME = 8'h77;
   localparam logic [7:0] RFTX_MASK_DRV_CTRL = 8'h7f;
   localparam logic [7:0] RFTX_MASK_COND = 8'h3f;
   // Modulator source encodings
   localparam logic [1:0] RFTX_SRC_LOW = 2'h0;
   localparam logic [1:0] RFTX_SRC_HIGH = 2'h1;
   localparam logic [1:0] RFTX_SRC_ENC = 2'h2;
   // Driver conductance for full-depth keying (driver off)
   localparam logic [5:0] RFTX_COND_OFF = 6'h00;
   // Read data for unmapped or undefined content
   localparam logic [7:0] RFTX_READ_NONE = 8'h00;
endpackage

// [design/rftx_driver_lane.sv]
// One antenna driver lane: carrier gating, inversion and conductance choice
`timescale 1ns/100ps
`default_nettype none
module rftx_driver_lane (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   // Controls
   input wire logic i_rf_enable,
   input wire logic i_plain_carrier,
   input wire logic i_invert,
   input wire logic i_mod_active,
   input wire logic i_carrier,
   input wire logic [5:0] i_cw_cond,
   input wire logic [5:0] i_mod_cond,
   // Driver outputs
   output logic o_drive,
   output logic [5:0] o_cond
);
   import rftx_pkg::*;

   typedef struct packed {
      logic drive;
      logic [5:0] cond;
   } rftx_lane_t;

   rftx_lane_t st;
   rftx_lane_t next_st;
   logic keyed;

   // Keying applies only when modulation is allowed on this lane
   always_comb begin
      keyed = i_mod_active && !i_plain_carrier;
      next_st = st;
      if (!i_rf_enable) begin
         next_st.drive = 1'b0;  // Constant level when disabled
      end else begin
         next_st.drive = i_carrier ^ i_invert;
      end
      next_st.cond = keyed ? i_mod_cond : i_cw_cond;
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_drive = st.drive;
   assign o_cond = st.cond;
endmodule // rftx_driver_lane
`default_nettype wire

// [verification/rftx_host_model.sv]
// Host processor model driving the parallel register port
`timescale 1ns/100ps
`default_nettype none
module rftx_host_model (
   // Clock and read data
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   // Register port strobes
   output logic [7:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_wdata
);
   import rftx_pkg::*;
   ////////////////////////////////////////////////////////////
   // Idle port from time zero
   initial begin
      o_addr = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end
   // One-cycle read strobe; data taken only once the answer has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      #1 d = i_rdata;
   endtask
   // Write; reserved bits of the conductance and driver control registers kept as a careful host keeps them
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [7:0] old;
      if (a == RFTX_ADDR_CW_COND || a == RFTX_ADDR_MOD_COND) begin
         rd(a, old);
         v[7:6] = old[7:6];
      end
      if (a == RFTX_ADDR_DRV_CTRL) begin
         v[7] = 1'b0;
      end
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= v;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
   endtask
endmodule // rftx_host_model
`default_nettype wire

// [verification/rftx_regs_tb.sv]
// Self-checking bench for the reader framing register bank
`timescale 1ns/100ps
`default_nettype none
module rftx_regs_tb;
   import rftx_pkg::*;
   logic clk, rstn, ce, wr, rd, cdone, c8, rxd, txd, enc, car, mi, da, db;
   logic [7:0] addr, wdata, rdata, tmr, clo, chi, got;
   logic [2:0] ofs, lbc;
   logic [5:0] ca, cb;
   int m_bf, m_dc, m_cw, m_mod, bad_count, checks_done;
   ////////////////////////////////////////////////////////////
   // 200 MHz clock
   always #2.5 clk = ~clk;
   // Device and host
   rftx_regs i_rftx_regs (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_addr(addr),
      .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
      .i_timer_count_value(tmr), .i_crc_low_byte(clo), .i_crc_high_byte(chi),
      .i_crc_done_flag(cdone), .i_crc_8bit(c8), .i_rx_done(rxd), .i_tx_done(txd),
      .i_encoder_data(enc), .i_carrier(car), .o_receive_bit_offset(ofs),
      .o_final_byte_bit_count(lbc), .o_modulator_input(mi), .o_antenna_driver_a(da),
      .o_cond_a(ca), .o_antenna_driver_b(db), .o_cond_b(cb));
   rftx_host_model i_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
      .o_rd(rd), .o_wdata(wdata));
   ////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Reference read data from the bench's own register copy
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      case (a)
         RFTX_ADDR_TIMER_COUNT: return tmr;
         RFTX_ADDR_CRC_LOW: return cdone ? clo : 8'h00;
         RFTX_ADDR_CRC_HIGH: return (cdone && !c8) ? chi : 8'h00;
         RFTX_ADDR_BIT_FRAME: return 8'(m_bf & 'h77);
         RFTX_ADDR_DRV_CTRL: return 8'(m_dc);
         RFTX_ADDR_CW_COND: return 8'(m_cw);
         RFTX_ADDR_MOD_COND: return 8'(m_mod);
         default: return 8'h00;
      endcase
   endfunction
   task automatic rchk(input logic [7:0] a);
      i_host.rd(a, got);
      chk("read data", exp_rd(a), got);
   endtask
   // Write through the host and mirror it in the copy
   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      if (a == RFTX_ADDR_BIT_FRAME) m_bf = v;
      if (a == RFTX_ADDR_DRV_CTRL) m_dc = v & 'h7f;
      if (a == RFTX_ADDR_CW_COND) m_cw = (m_cw & 'hc0) | (v & 'h3f);
      if (a == RFTX_ADDR_MOD_COND) m_mod = (m_mod & 'hc0) | (v & 'h3f);
      i_host.wr(a, v);
   endtask
   // Driver outputs once the two-stage path has settled
   task automatic drv_chk();
      int src, mact, key, cw;
      src = (m_dc >> 5) & 3;
      mact = (src == 1) || (src == 2 && enc);
      key = m_dc[4] ? 0 : m_mod & 'h3f;
      cw = m_cw & 'h3f;
      repeat (4) @(posedge clk);
      #1;
      chk("mod input", 8'(mact), {7'h0, mi});
      chk("cond a", 8'(mact ? key : cw), {2'h0, ca});
      chk("cond b", 8'(mact && !m_dc[2] ? key : cw), {2'h0, cb});
      chk("drive a", 8'(m_dc[0] & car), {7'h0, da});
      chk("drive b", 8'(m_dc[1] & (car ^ m_dc[3])), {7'h0, db});
   endtask
   // Verdict, the single end of the run
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 0; rstn = 0; ce = 1; tmr = 0; clo = 0; chi = 0; cdone = 0; c8 = 0;
      rxd = 0; txd = 0; enc = 0; car = 0; bad_count = 0; checks_done = 0;
      m_bf = 'h00; m_dc = 'h48; m_cw = 'h3f; m_mod = 'h05;
      void'($urandom(36409));
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 'h0f; a <= 'h13; a++) rchk(8'(a));
      drv_chk();
      // Status bytes under every flag combination; RO write ignored
      wreg(RFTX_ADDR_TIMER_COUNT, 8'hff);
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         tmr <= 8'($urandom);
         clo <= 8'($urandom);
         chi <= 8'($urandom);
         cdone <= k[0];
         c8 <= k[1];
         rchk(RFTX_ADDR_TIMER_COUNT);
         rchk(RFTX_ADDR_CRC_LOW);
         rchk(RFTX_ADDR_CRC_HIGH);
      end
      // Every offset and bit count, then the completion clears
      for (int k = 0; k < 8; k++) begin
         wreg(RFTX_ADDR_BIT_FRAME, {1'b0, 3'(k), 1'b0, 3'(7 - k)} ^ 8'($urandom & 'h88));
         #1;
         chk("rx offset", 8'(k), {5'h0, ofs});
         chk("last bits", 8'(7 - k), {5'h0, lbc});
         rchk(RFTX_ADDR_BIT_FRAME);
         @(posedge clk) rxd <= 1'b1;
         @(posedge clk) rxd <= 1'b0;
         #1;
         chk("rx offset", 8'h00, {5'h0, ofs});
         chk("last bits", 8'(7 - k), {5'h0, lbc});
         @(posedge clk) txd <= 1'b1;
         @(posedge clk) txd <= 1'b0;
         #1;
         chk("last bits", 8'h00, {5'h0, lbc});
         m_bf = 0;
         rchk(RFTX_ADDR_BIT_FRAME);
      end
      // Completion beats a host write landing on the same edge
      fork
         i_host.wr(RFTX_ADDR_BIT_FRAME, 8'h77);
         begin
            @(posedge clk) rxd <= 1'b1;
            @(posedge clk) rxd <= 1'b0;
         end
      join
      #1;
      chk("rx offset", 8'h00, {5'h0, ofs});
      chk("last bits", 8'h07, {5'h0, lbc});
      fork
         i_host.wr(RFTX_ADDR_BIT_FRAME, 8'h77);
         begin
            @(posedge clk) txd <= 1'b1;
            @(posedge clk) txd <= 1'b0;
         end
      join
      #1;
      chk("rx offset", 8'h07, {5'h0, ofs});
      chk("last bits", 8'h00, {5'h0, lbc});
      m_bf = 'h70;
      rchk(RFTX_ADDR_BIT_FRAME);
      // Frozen clock enable takes no write
      @(posedge clk) ce <= 1'b0;
      i_host.wr(RFTX_ADDR_BIT_FRAME, 8'h77);
      @(posedge clk) ce <= 1'b1;
      rchk(RFTX_ADDR_BIT_FRAME);
      // All driver control settings against random conductances
      for (int k = 0; k < 128; k++) begin
         if (k % 16 == 0) begin
            wreg(RFTX_ADDR_CW_COND, 8'($urandom));
            wreg(RFTX_ADDR_MOD_COND, 8'($urandom));
            rchk(RFTX_ADDR_CW_COND);
            rchk(RFTX_ADDR_MOD_COND);
         end
         @(posedge clk);
         enc <= 1'($urandom);
         car <= 1'($urandom);
         wreg(RFTX_ADDR_DRV_CTRL, 8'(k));
         rchk(RFTX_ADDR_DRV_CTRL);
         drv_chk();
      end
      results();
   end
   // Hang guard, far beyond the under two thousand cycles expected
   initial begin
      #100000;
      bad_count++;
      results();
   end
endmodule // rftx_regs_tb
`default_nettype wire
